// ---- verilog/decoder_pkg.sv ----
// Function
// [RULE_01] Inherent instruction is one byte only
// [RULE_02] Immediate: opcode then one operand byte
// [RULE_03] Short direct: one address byte, page zero
// [RULE_04] Long direct: two address bytes, full space
// [RULE_05] Indexed address is unsigned index plus offset
// [RULE_06] No-offset indexed: index register alone
// [RULE_07] Long indexed: two-byte offset, full space
// [RULE_08] Short indirect: byte pointer from page zero
// [RULE_09] Long indirect: word pointer from page zero
// [RULE_10] Indirect indexed adds index to pointer
// [RULE_11] Short indirect indexed reaches up to 1FE
// [RULE_12] Relative adds signed 8-bit offset to PC
// [RULE_13] Indirect relative reads offset from memory
// [RULE_14] Read-modify-write uses short forms only
// [RULE_15] Y prefix swaps X for Y
// [RULE_16] Indirect prefix turns direct into indirect
// [RULE_17] Y indirect prefix swaps X for Y
// [RULE_18] Optional prefix, then up to two bytes
// [RULE_19] Unknown code raises a reset
// [RULE_20] Prefix plus valid opcode never resets
// [RULE_21] Branch on N, Z, C, H, mask bits
// [RULE_22] Branch on interrupt pin level
// [RULE_23] PC passes every consumed byte
// [RULE_24] Unsigned branches use carry and zero
package decoder_pkg;
  localparam logic [7:0] PREFIX_Y = 8'h90;
  localparam logic [7:0] PREFIX_YIND = 8'h91;
  localparam logic [7:0] PREFIX_IND = 8'h92;
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] RESET_PC = 16'h0000;

  // Opcode column groups (high nibble)
  localparam logic [3:0] COL_BTJ = 4'h0;
  localparam logic [3:0] COL_BSR = 4'h1;
  localparam logic [3:0] COL_JR = 4'h2;
  localparam logic [3:0] COL_RMW_DIR = 4'h3;
  localparam logic [3:0] COL_RMW_A = 4'h4;
  localparam logic [3:0] COL_RMW_X = 4'h5;
  localparam logic [3:0] COL_RMW_SIX = 4'h6;
  localparam logic [3:0] COL_RMW_IX = 4'h7;
  localparam logic [3:0] COL_SYS = 4'h8;
  localparam logic [3:0] COL_REG = 4'h9;
  localparam logic [3:0] COL_IMM = 4'hA;
  localparam logic [3:0] COL_DIR = 4'hB;
  localparam logic [3:0] COL_LDIR = 4'hC;
  localparam logic [3:0] COL_LIX = 4'hD;
  localparam logic [3:0] COL_SIX = 4'hE;
  localparam logic [3:0] COL_IX = 4'hF;

  // Condition codes of the relative branch column (low nibble)
  localparam logic [3:0] CND_ALWAYS = 4'h0;
  localparam logic [3:0] CND_NEVER = 4'h1;
  localparam logic [3:0] CND_UGT = 4'h2;
  localparam logic [3:0] CND_ULE = 4'h3;
  localparam logic [3:0] CND_NC = 4'h4;
  localparam logic [3:0] CND_C = 4'h5;
  localparam logic [3:0] CND_NE = 4'h6;
  localparam logic [3:0] CND_EQ = 4'h7;
  localparam logic [3:0] CND_NH = 4'h8;
  localparam logic [3:0] CND_H = 4'h9;
  localparam logic [3:0] CND_PL = 4'hA;
  localparam logic [3:0] CND_MI = 4'hB;
  localparam logic [3:0] CND_NM = 4'hC;
  localparam logic [3:0] CND_M = 4'hD;
  localparam logic [3:0] CND_IL = 4'hE;
  localparam logic [3:0] CND_IH = 4'hF;
  localparam logic [7:0] OP_RELATIVE_SUBROUTINE_CALL = 8'hAD;

  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_SDIR, MODE_LDIR, MODE_IX0, MODE_SIX,
    MODE_LIX, MODE_SIND, MODE_LIND, MODE_SINDIX, MODE_LINDIX,
    MODE_REL, MODE_RELIND
  } mode_e;

  typedef struct packed {
    logic i1;
    logic h;
    logic i0;
    logic n;
    logic z;
    logic c;
  } flags_s;

  typedef struct packed {
    logic [15:0] addr;
    logic valid;
  } bus_req_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [15:0] ea;
    logic [15:0] nextPc;
    logic [15:0] branchPc;
    logic useY;
    logic taken;
    mode_e mode;
  } decoded_s;
endpackage : decoder_pkg

// ---- verilog/branch_condition.sv ----
`timescale 1ns/1ns
module branch_condition (
  input wire logic [3:0] cond,
  input wire decoder_pkg::flags_s flags,
  input wire logic irqPin,
  output logic taken
);
  // Condition table for relative branches
  always_comb begin
    case (cond)
      decoder_pkg::CND_ALWAYS: taken = 1'b1;
      decoder_pkg::CND_NEVER: taken = 1'b0;
      decoder_pkg::CND_UGT: taken = ~(flags.c | flags.z); // RULE_24
      decoder_pkg::CND_ULE: taken = flags.c | flags.z; // RULE_24
      decoder_pkg::CND_NC: taken = ~flags.c; // RULE_24
      decoder_pkg::CND_C: taken = flags.c; // RULE_24
      decoder_pkg::CND_NE: taken = ~flags.z; // RULE_21
      decoder_pkg::CND_EQ: taken = flags.z; // RULE_21
      decoder_pkg::CND_NH: taken = ~flags.h; // RULE_21
      decoder_pkg::CND_H: taken = flags.h; // RULE_21
      decoder_pkg::CND_PL: taken = ~flags.n; // RULE_21
      decoder_pkg::CND_MI: taken = flags.n; // RULE_21
      decoder_pkg::CND_NM: taken = ~(flags.i1 & flags.i0); // RULE_21
      decoder_pkg::CND_M: taken = flags.i1 & flags.i0; // RULE_21
      decoder_pkg::CND_IL: taken = ~irqPin; // RULE_22
      decoder_pkg::CND_IH: taken = irqPin; // RULE_22
      default: taken = 1'b0;
    endcase
  end
endmodule : branch_condition

// ---- verilog/instr_decoder.sv ----
`timescale 1ns/1ns
module instr_decoder (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] pc,
  input wire logic [7:0] xReg,
  input wire logic [7:0] yReg,
  input wire decoder_pkg::flags_s flags,
  input wire logic irqPin,
  output decoder_pkg::bus_req_s memReq,
  input wire logic [7:0] memData,
  output decoder_pkg::decoded_s result,
  output logic done,
  output logic illegalReset
);
  typedef enum {
    S_IDLE, S_FETCH_OP, S_OPER1, S_OPER2, S_PTR_HI, S_PTR_LO, S_FINISH
  } state_e;

  state_e state;
  logic [15:0] fetchPc;
  logic [7:0] prefix;
  logic [7:0] opcode;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [7:0] ptrHi;
  logic [7:0] ptrLo;
  decoder_pkg::mode_e mode;
  logic [15:0] ptrAddr;

  // Classify a fetched opcode into addressing mode without prefix
  function automatic decoder_pkg::mode_e base_mode(input logic [7:0] op);
    logic [3:0] col;
    col = op[7:4];
    case (col)
      decoder_pkg::COL_BTJ: base_mode = decoder_pkg::MODE_SDIR;
      decoder_pkg::COL_BSR: base_mode = decoder_pkg::MODE_SDIR;
      decoder_pkg::COL_JR: base_mode = decoder_pkg::MODE_REL;
      decoder_pkg::COL_RMW_DIR: base_mode = decoder_pkg::MODE_SDIR;
      decoder_pkg::COL_RMW_A: base_mode = decoder_pkg::MODE_INH;
      decoder_pkg::COL_RMW_X: base_mode = decoder_pkg::MODE_INH;
      decoder_pkg::COL_RMW_SIX: base_mode = decoder_pkg::MODE_SIX;
      decoder_pkg::COL_RMW_IX: base_mode = decoder_pkg::MODE_IX0;
      decoder_pkg::COL_SYS: base_mode = decoder_pkg::MODE_INH;
      decoder_pkg::COL_REG: base_mode = decoder_pkg::MODE_INH;
      decoder_pkg::COL_IMM: base_mode = (op == decoder_pkg::OP_RELATIVE_SUBROUTINE_CALL) ?
          decoder_pkg::MODE_REL : decoder_pkg::MODE_IMM;
      decoder_pkg::COL_DIR: base_mode = decoder_pkg::MODE_SDIR;
      decoder_pkg::COL_LDIR: base_mode = decoder_pkg::MODE_LDIR;
      decoder_pkg::COL_LIX: base_mode = decoder_pkg::MODE_LIX;
      decoder_pkg::COL_SIX: base_mode = decoder_pkg::MODE_SIX;
      default: base_mode = decoder_pkg::MODE_IX0;
    endcase
  endfunction : base_mode

  // Apply the indirection prefix to a base mode
  function automatic decoder_pkg::mode_e to_indirect(
      input decoder_pkg::mode_e m);
    case (m)
      decoder_pkg::MODE_SDIR: to_indirect = decoder_pkg::MODE_SIND;
      decoder_pkg::MODE_LDIR: to_indirect = decoder_pkg::MODE_LIND;
      decoder_pkg::MODE_SIX: to_indirect = decoder_pkg::MODE_SINDIX;
      decoder_pkg::MODE_LIX: to_indirect = decoder_pkg::MODE_LINDIX;
      decoder_pkg::MODE_REL: to_indirect = decoder_pkg::MODE_RELIND;
      default: to_indirect = m;
    endcase
  endfunction : to_indirect

  // Operand bytes following the opcode for each mode
  function automatic logic [1:0] operand_bytes(input decoder_pkg::mode_e m);
    case (m)
      decoder_pkg::MODE_INH: operand_bytes = 2'h0;
      decoder_pkg::MODE_IX0: operand_bytes = 2'h0;
      decoder_pkg::MODE_LDIR: operand_bytes = 2'h2;
      decoder_pkg::MODE_LIX: operand_bytes = 2'h2;
      default: operand_bytes = 2'h1;
    endcase
  endfunction : operand_bytes

  // Opcodes with no defined meaning in this core
  function automatic logic is_illegal(input logic [7:0] op);
    is_illegal = (op == 8'h8B) || (op == 8'h8C) || (op == 8'h9A) ||
        (op == 8'h9B) || (op == 8'h9C) || (op == 8'h9D) ||
        (op == 8'h9E) || (op == 8'h9F) || (op == 8'h87) ||
        (op == 8'h88) || (op == 8'h89) || (op == 8'h8D);
  endfunction : is_illegal

  wire logic isPrefix = (memData == decoder_pkg::PREFIX_Y) ||
      (memData == decoder_pkg::PREFIX_YIND) ||
      (memData == decoder_pkg::PREFIX_IND);
  wire logic firstByte = (state == S_FETCH_OP) && (prefix == 8'h00);
  // RULE_19 RULE_20: only an unknown code at opcode position resets
  wire logic badCode = (state == S_FETCH_OP) && !(firstByte && isPrefix) &&
      is_illegal(memData);
  wire decoder_pkg::mode_e rawMode = base_mode(memData);
  wire logic wantInd = (prefix == decoder_pkg::PREFIX_IND) ||
      (prefix == decoder_pkg::PREFIX_YIND);
  wire decoder_pkg::mode_e opMode = wantInd ? to_indirect(rawMode) :
      rawMode; // RULE_16
  wire logic rmwOp = (memData[7:4] <= decoder_pkg::COL_RMW_IX) &&
      (memData[7:4] != decoder_pkg::COL_JR);
  wire logic [1:0] opBytes = operand_bytes(opMode); // RULE_18
  wire logic useY = (prefix == decoder_pkg::PREFIX_Y) ||
      (prefix == decoder_pkg::PREFIX_YIND); // RULE_15 RULE_17
  wire logic [7:0] idx = useY ? yReg : xReg;
  wire logic longPtr = (mode == decoder_pkg::MODE_LIND) ||
      (mode == decoder_pkg::MODE_LINDIX); // RULE_09
  wire logic ptrMode = (mode == decoder_pkg::MODE_SIND) ||
      (mode == decoder_pkg::MODE_LIND) ||
      (mode == decoder_pkg::MODE_SINDIX) ||
      (mode == decoder_pkg::MODE_LINDIX) ||
      (mode == decoder_pkg::MODE_RELIND); // RULE_13
  wire logic [15:0] ptrVal = {longPtr ? ptrHi : 8'h00, ptrLo};
  wire logic [15:0] ptrNext = ptrAddr + 16'h0001;
  wire logic [7:0] relOff = (mode == decoder_pkg::MODE_RELIND) ? ptrLo :
      byte1;
  wire logic condTaken;

  branch_condition condUnit (
    .cond(opcode[3:0]),
    .flags(flags),
    .irqPin(irqPin),
    .taken(condTaken)
  );

  // Effective address for each mode
  logic [15:0] eaCalc;
  always_comb begin
    case (mode)
      decoder_pkg::MODE_SDIR: eaCalc = {8'h00, byte1}; // RULE_03
      decoder_pkg::MODE_LDIR: eaCalc = {byte1, byte2}; // RULE_04
      decoder_pkg::MODE_IX0: eaCalc = {8'h00, idx}; // RULE_06
      decoder_pkg::MODE_SIX: eaCalc = {8'h00, byte1} + {8'h00, idx}; // RULE_05
      decoder_pkg::MODE_LIX: eaCalc = {byte1, byte2} + {8'h00, idx}; // RULE_07
      decoder_pkg::MODE_SIND: eaCalc = ptrVal; // RULE_08
      decoder_pkg::MODE_LIND: eaCalc = ptrVal; // RULE_09
      decoder_pkg::MODE_SINDIX: eaCalc = ptrVal + {8'h00, idx}; // RULE_11
      decoder_pkg::MODE_LINDIX: eaCalc = ptrVal + {8'h00, idx}; // RULE_10
      default: eaCalc = 16'h0000; // RULE_01 RULE_02
    endcase
  end

  // Bus address per fetch state
  assign memReq.valid = (state != S_IDLE) && (state != S_FINISH);
  assign memReq.addr = ((state == S_PTR_HI) || (state == S_PTR_LO)) ?
      ptrAddr : fetchPc;

  // Decode steps shared by the sequencer and the registers
  wire logic enterDecode = (state == S_IDLE) && start;
  wire logic prefixTaken = (state == S_FETCH_OP) && firstByte && isPrefix;
  wire logic opcodeTaken = (state == S_FETCH_OP) && !badCode &&
      !prefixTaken;
  wire logic streamByte = (state == S_FETCH_OP) || (state == S_OPER1) ||
      (state == S_OPER2); // RULE_23
  wire logic wordOffset = (mode == decoder_pkg::MODE_LDIR) ||
      (mode == decoder_pkg::MODE_LIX); // RULE_04 RULE_07
  // RULE_14: read-modify-write keeps short forms
  wire decoder_pkg::mode_e shortMode = (rmwOp &&
      opMode == decoder_pkg::MODE_LIND) ? decoder_pkg::MODE_SIND : opMode;
  // RULE_12: signed offset from the address after the instruction
  wire logic [15:0] branchTarget = fetchPc + {{8{relOff[7]}}, relOff};
  wire logic jumpTaken = (opcode[7:4] == decoder_pkg::COL_JR) ? condTaken :
      (opcode == decoder_pkg::OP_RELATIVE_SUBROUTINE_CALL);

  // Next value of the sequencer state
  state_e next_state;

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_FETCH_OP;
        end
      end
      S_FETCH_OP: begin
        if (badCode) begin
          next_state = S_IDLE; // RULE_19
        end else if (opcodeTaken) begin
          next_state = (opBytes == 2'h0) ? S_FINISH : S_OPER1; // RULE_01
        end
      end
      S_OPER1: begin
        if (wordOffset) begin
          next_state = S_OPER2;
        end else if (ptrMode) begin
          next_state = longPtr ? S_PTR_HI : S_PTR_LO; // RULE_09
        end else begin
          next_state = S_FINISH;
        end
      end
      S_OPER2: next_state = S_FINISH;
      S_PTR_HI: next_state = S_PTR_LO;
      S_PTR_LO: next_state = S_FINISH;
      S_FINISH: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Fetch pointer steps over every byte taken from the stream
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetchPc <= decoder_pkg::RESET_PC;
    end else if (enterDecode) begin
      fetchPc <= pc;
    end else if (streamByte) begin
      fetchPc <= fetchPc + 16'h0001; // RULE_23
    end
  end

  // Prefix seen ahead of the opcode
  always_ff @(posedge sys_clk) begin
    if (rst || enterDecode) begin
      prefix <= 8'h00;
    end else if (prefixTaken) begin
      prefix <= memData; // RULE_18
    end
  end

  // Opcode and its addressing mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opcode <= 8'h00;
      mode <= decoder_pkg::MODE_INH;
    end else if (opcodeTaken) begin
      opcode <= memData;
      mode <= shortMode; // RULE_14 RULE_16
    end
  end

  // Operand bytes after the opcode
  always_ff @(posedge sys_clk) begin
    if (rst || opcodeTaken) begin
      byte1 <= 8'h00;
      byte2 <= 8'h00;
    end else if (state == S_OPER1) begin
      byte1 <= memData; // RULE_02
    end else if (state == S_OPER2) begin
      byte2 <= memData; // RULE_04
    end
  end

  // Pointer location in page zero, stepped for the low byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptrAddr <= 16'h0000;
    end else if (state == S_OPER1) begin
      ptrAddr <= {decoder_pkg::PAGE_ZERO_HI, memData}; // RULE_08
    end else if (state == S_PTR_HI) begin
      ptrAddr <= ptrNext;
    end
  end

  // Pointer bytes, high first for a word pointer
  always_ff @(posedge sys_clk) begin
    if (rst || opcodeTaken) begin
      ptrHi <= 8'h00;
      ptrLo <= 8'h00;
    end else if (state == S_PTR_HI) begin
      ptrHi <= memData; // RULE_09
    end else if (state == S_PTR_LO) begin
      ptrLo <= memData; // RULE_08
    end
  end

  // Completion and illegal-code pulses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done <= 1'b0;
      illegalReset <= 1'b0;
    end else begin
      done <= (state == S_FINISH);
      illegalReset <= badCode; // RULE_19
    end
  end

  // Result registers, loaded as the decode finishes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result <= '0;
    end else if (state == S_FINISH) begin
      result.opcode <= opcode;
      result.operand <= byte1; // RULE_02
      result.ea <= eaCalc;
      result.nextPc <= fetchPc; // RULE_23
      result.branchPc <= branchTarget; // RULE_12
      result.useY <= useY;
      result.taken <= jumpTaken;
      result.mode <= mode;
    end
  end
endmodule : instr_decoder

// ---- tb/decoder_properties.sv ----
`timescale 1ns/1ns
module decoder_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] pc,
  input wire logic [7:0] xReg,
  input wire logic [7:0] yReg,
  input wire decoder_pkg::flags_s flags,
  input wire logic irqPin,
  input wire decoder_pkg::bus_req_s memReq,
  input wire logic [7:0] memData,
  input wire decoder_pkg::decoded_s result,
  input wire logic done,
  input wire logic illegalReset
);
  logic [3:0] fetchCnt;
  logic [7:0] idx;
  // Bytes fetched by the decode under way
  always_ff @(posedge sys_clk) begin
    if (rst || done || illegalReset) fetchCnt <= 4'h0;
    else fetchCnt <= fetchCnt + {3'h0, memReq.valid};
  end
  // Index register chosen by the decode
  assign idx = result.useY ? yReg : xReg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_fetch_begin;
    $rose(memReq.valid);
  endsequence
  sequence s_finish;
    done || illegalReset;
  endsequence
  a_finish_bound: assert property (
    s_fetch_begin |-> ##[1:10] s_finish) else $error("decode never ends");
  a_done_pulse: assert property (
    done |=> !done) else $error("done longer than a cycle");
  a_illegal_pulse: assert property (
    illegalReset |=> !illegalReset && !done) else $error("bad illegal pulse");
  a_pc_advance: assert property (
    done && result.mode inside {decoder_pkg::MODE_INH, decoder_pkg::MODE_IMM,
    decoder_pkg::MODE_SDIR, decoder_pkg::MODE_LDIR, decoder_pkg::MODE_SIX,
    decoder_pkg::MODE_LIX} |-> result.nextPc == pc + {12'h000, fetchCnt})
    else $error("next pc not past fetched bytes");
  a_index_sum: assert property (
    done && result.mode == decoder_pkg::MODE_SIX |->
    result.ea == {8'h00, idx} + {8'h00, result.operand})
    else $error("indexed sum wrong");
  a_index_only: assert property (
    done && result.mode == decoder_pkg::MODE_IX0 |-> result.ea == {8'h00, idx})
    else $error("no-offset index address wrong");
  a_short_page: assert property (
    done && result.mode inside {decoder_pkg::MODE_SDIR, decoder_pkg::MODE_SIND}
    |-> result.ea[15:8] == 8'h00) else $error("short form left page zero");
  a_branch_target: assert property (
    done && result.mode == decoder_pkg::MODE_REL |-> result.branchPc ==
    result.nextPc + {{8{result.operand[7]}}, result.operand})
    else $error("branch target wrong");
  a_irq_branch: assert property (
    done && result.opcode[7:1] == 7'h17 |->
    result.taken == (irqPin ~^ result.opcode[0])) else $error("pin branch");
  a_mask_branch: assert property (
    done && result.opcode[7:1] == 7'h16 |->
    result.taken == ((flags.i1 && flags.i0) ~^ result.opcode[0]))
    else $error("mask branch wrong");
  a_rmw_short: assert property (
    done && result.opcode[7:4] inside
    {[decoder_pkg::COL_RMW_DIR:decoder_pkg::COL_RMW_IX]} |->
    !(result.mode inside {decoder_pkg::MODE_LDIR, decoder_pkg::MODE_LIX,
    decoder_pkg::MODE_LIND, decoder_pkg::MODE_LINDIX}))
    else $error("read-modify-write used a long form");
endmodule : decoder_properties
bind instr_decoder decoder_properties u_props (.sys_clk(sys_clk), .rst(rst),
  .start(start), .pc(pc), .xReg(xReg), .yReg(yReg), .flags(flags),
  .irqPin(irqPin), .memReq(memReq), .memData(memData), .result(result),
  .done(done), .illegalReset(illegalReset));

// ---- tb/program_memory.sv ----
`timescale 1ns/1ns
module program_memory (
  input wire logic sys_clk,
  input wire decoder_pkg::bus_req_s memReq,
  output logic [7:0] memData
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastData = 8'hA5;
  // Idle bus shows the inverse of the last byte
  assign memData = memReq.valid ? mem[memReq.addr] : ~lastData;
  always_ff @(posedge sys_clk) begin
    if (memReq.valid) lastData <= mem[memReq.addr];
  end
endmodule : program_memory

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic sys_clk, rst, start, irqPin, done, illegalReset, sawIll;
  logic [15:0] pc;
  logic [7:0] xReg, yReg, memData;
  decoder_pkg::flags_s flags;
  decoder_pkg::bus_req_s memReq;
  decoder_pkg::decoded_s result;
  int miscompares, comparisons;
  instr_decoder u_dut (.sys_clk(sys_clk), .rst(rst), .start(start), .pc(pc),
    .xReg(xReg), .yReg(yReg), .flags(flags), .irqPin(irqPin),
    .memReq(memReq), .memData(memData), .result(result), .done(done),
    .illegalReset(illegalReset));
  program_memory u_mem (.sys_clk(sys_clk), .memReq(memReq), .memData(memData));
  // Clock of 100 ns
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task give_verdict;
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Place three bytes, decode there, wait for done or illegal
  task run(input logic [15:0] a, input logic [7:0] b0, b1, b2);
    int i;
    u_mem.mem[a] = b0;
    u_mem.mem[a + 16'h1] = b1;
    u_mem.mem[a + 16'h2] = b2;
    pc = a;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    sawIll = 1'b0;
    for (i = 0; i < 20 && done !== 1'b1 && !sawIll; i++) begin
      @(negedge sys_clk);
      sawIll = (illegalReset === 1'b1);
    end
    if (i == 20) begin
      `CHECK("finished", 1'b1, done)
      give_verdict();
    end
    @(negedge sys_clk);
  endtask : run
  task chk(input decoder_pkg::mode_e m, input logic [15:0] np, e, input ce);
    `CHECK("illegal", 1'b0, sawIll)
    `CHECK("mode", m, result.mode)
    `CHECK("nextPc", np, result.nextPc)
    if (ce) `CHECK("ea", e, result.ea)
  endtask : chk
  // Plain, direct and indexed forms
  task t_modes;
    xReg = 8'hFF;
    yReg = 8'h20;
    run(16'h0100, 8'h81, 8'h00, 8'h00);
    chk(decoder_pkg::MODE_INH, 16'h0101, 16'h0000, 1'b0);
    run(16'h0110, 8'hA6, 8'h55, 8'h00);
    chk(decoder_pkg::MODE_IMM, 16'h0112, 16'h0000, 1'b0);
    `CHECK("operand", 8'h55, result.operand)
    run(16'h0120, 8'hB6, 8'h80, 8'h00);
    chk(decoder_pkg::MODE_SDIR, 16'h0122, 16'h0080, 1'b1);
    run(16'h0130, 8'hC6, 8'h12, 8'h34);
    chk(decoder_pkg::MODE_LDIR, 16'h0133, 16'h1234, 1'b1);
    run(16'h0140, 8'hE6, 8'hFF, 8'h00);
    chk(decoder_pkg::MODE_SIX, 16'h0142, 16'h01FE, 1'b1);
    run(16'h0150, 8'hF6, 8'h00, 8'h00);
    chk(decoder_pkg::MODE_IX0, 16'h0151, 16'h00FF, 1'b1);
    run(16'h0160, 8'hD6, 8'h10, 8'h00);
    chk(decoder_pkg::MODE_LIX, 16'h0163, 16'h10FF, 1'b1);
    run(16'h0170, 8'h90, 8'hE6, 8'h10);
    chk(decoder_pkg::MODE_SIX, 16'h0173, 16'h0030, 1'b1);
    `CHECK("useY", 1'b1, result.useY)
  endtask : t_modes
  // Pointer forms through the prefixes, then a plain relative call; pointer 1234 sits at 0040
  task t_indirect;
    run(16'h0180, 8'h92, 8'hB6, 8'h40);
    chk(decoder_pkg::MODE_SIND, 16'h0183, 16'h0012, 1'b1);
    run(16'h0190, 8'h92, 8'hC6, 8'h40);
    chk(decoder_pkg::MODE_LIND, 16'h0193, 16'h1234, 1'b1);
    run(16'h01A0, 8'h92, 8'hE6, 8'h40);
    chk(decoder_pkg::MODE_SINDIX, 16'h01A3, 16'h0111, 1'b1);
    run(16'h01B0, 8'h92, 8'hD6, 8'h40);
    chk(decoder_pkg::MODE_LINDIX, 16'h01B3, 16'h1333, 1'b1);
    run(16'h01C0, 8'h91, 8'hE6, 8'h40);
    chk(decoder_pkg::MODE_SINDIX, 16'h01C3, 16'h0032, 1'b1);
    run(16'h01D0, 8'h92, 8'h3C, 8'h40);
    chk(decoder_pkg::MODE_SIND, 16'h01D3, 16'h0012, 1'b1);
    run(16'h01E0, 8'h92, 8'h20, 8'h40);
    chk(decoder_pkg::MODE_RELIND, 16'h01E3, 16'h0000, 1'b0);
    `CHECK("target", 16'h01F5, result.branchPc)
    run(16'h01F0, 8'hAD, 8'h10, 8'h00);
    chk(decoder_pkg::MODE_REL, 16'h01F2, 16'h0000, 1'b0);
    `CHECK("opcode", 8'hAD, result.opcode)
    `CHECK("taken", 1'b1, result.taken)
    `CHECK("target", 16'h0202, result.branchPc)
  endtask : t_indirect
  // Every branch condition under three flag settings
  task t_branches;
    logic [15:0] a, tv;
    decoder_pkg::flags_s f;
    for (int p = 0; p < 3; p++) begin
      f = (p == 0) ? 6'h00 : (p == 1) ? 6'h3F : 6'h25;
      flags = f;
      irqPin = p[0];
      tv = {irqPin, !irqPin, f.i1 & f.i0, !(f.i1 & f.i0), f.n, !f.n, f.h,
        !f.h, f.z, !f.z, f.c, !f.c, f.c | f.z, !(f.c | f.z), 2'b01};
      for (int k = 0; k < 16; k++) begin
        a = 16'h0200 + 16'(k * 16);
        run(a, {4'h2, 4'(k)}, 8'h80, 8'h00);
        chk(decoder_pkg::MODE_REL, a + 16'h2, 16'h0000, 1'b0);
        `CHECK("taken", tv[k], result.taken)
        `CHECK("target", a - 16'h007E, result.branchPc)
      end
    end
  endtask : t_branches
  // Unknown codes reset, prefix with a valid opcode does not
  task t_illegal;
    logic [95:0] bad;
    bad = 96'h8788898B8C8D9A9B9C9D9E9F;
    for (int i = 0; i < 12; i++) begin
      run(16'h0400 + 16'(i * 16), bad[95 - 8 * i -: 8], 8'h00, 8'h00);
      `CHECK("illegal", 1'b1, sawIll)
    end
    run(16'h0500, 8'h90, 8'h87, 8'h00);
    `CHECK("illegal", 1'b1, sawIll)
    run(16'h0510, 8'h92, 8'h81, 8'h00);
    `CHECK("illegal", 1'b0, sawIll)
  endtask : t_illegal
  // Reset, then the scenarios
  initial begin
    rst = 1'b1;
    start = 1'b0;
    pc = 16'h0000;
    xReg = 8'h00;
    yReg = 8'h00;
    flags = 6'h00;
    irqPin = 1'b0;
    sawIll = 1'b0;
    miscompares = 0;
    comparisons = 0;
    u_mem.mem[16'h0040] = 8'h12;
    u_mem.mem[16'h0041] = 8'h34;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_modes();
    t_indirect();
    t_branches();
    t_illegal();
    give_verdict();
  end
endmodule : testbench
